// ---- logic/nwrt_reply_timer.sv ----
// reply timing for commands that write non-volatile memory
`timescale 1ns/1ps
`default_nettype none
module nwrt_reply_timer #(
  parameter int unsigned SHORT_CYC_4 = nwrt_pkg::SHORT_CYC_4,
  parameter int unsigned SHORT_CYC_256 = nwrt_pkg::SHORT_CYC_256,
  parameter int unsigned LONG_CYC_4 = nwrt_pkg::LONG_CYC_4,
  parameter int unsigned LONG_CYC_256 = nwrt_pkg::LONG_CYC_256,
  parameter int unsigned NOMINAL_REPLY_DELAY = nwrt_pkg::NOMINAL_REPLY_DELAY,
  parameter int unsigned SLOT_STEP = nwrt_pkg::SLOT_STEP
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic carrier_i,
  input wire logic eof_i,
  input wire logic cmd_start_i,
  input wire logic cmd_long_i,
  input wire logic coding_256_i,
  input wire logic option_flag_i,
  output logic busy_o,
  output logic reply_go_o,
  output logic [nwrt_pkg::BYTE_BITS:1] reply_flags_o
);
  localparam int W = nwrt_pkg::CNT_W;
  localparam logic [W-1:0] NOM = W'(NOMINAL_REPLY_DELAY);
  localparam logic [W-1:0] STEP = W'(SLOT_STEP);

  nwrt_sync_if ev ();

  nwrt_link_sync u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .carrier_i(carrier_i),
    .eof_i(eof_i),
    .ev(ev.src)
  );

  nwrt_pkg::nwrt_state_t state_r;
  nwrt_pkg::nwrt_state_t state_nxt;
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic [W-1:0] slot_r;
  logic [W-1:0] slot_nxt;
  logic [W-1:0] need_r;
  logic opt_r;
  logic long_r;
  logic refused_r;
  logic go_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire [W-1:0] short_need = coding_256_i ? W'(SHORT_CYC_256) : W'(SHORT_CYC_4);
  wire [W-1:0] long_need = coding_256_i ? W'(LONG_CYC_256) : W'(LONG_CYC_4);
  wire [W-1:0] need_sel = cmd_long_i ? long_need : short_need;
  wire is_idle = (state_r == nwrt_pkg::NWRT_IDLE);
  wire accept = cmd_start_i & is_idle;
  wire refuse = cmd_start_i & ~is_idle;
  wire at_slot = (cnt_r == slot_r);
  wire slot_ok = (slot_r >= need_r);
  wire exec_done = (cnt_r >= need_r);
  wire [W-1:0] cnt_inc = ev.carrier_tick ? cnt_r + W'(1) : cnt_r;

  assign busy_o = ~is_idle;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_inc;
    slot_nxt = slot_r;
    go_nxt = 1'b0;
    case (state_r)
      nwrt_pkg::NWRT_IDLE:
      begin
        cnt_nxt = '0;
        if (accept)
          state_nxt = nwrt_pkg::NWRT_ARMED;
      end
      nwrt_pkg::NWRT_ARMED:
      begin
        cnt_nxt = '0;
        slot_nxt = NOM;
        if (ev.eof_rise)
          state_nxt = nwrt_pkg::NWRT_EXEC;
      end
      nwrt_pkg::NWRT_EXEC:
      begin
        if (opt_r)
        begin
          if (exec_done)
            state_nxt = nwrt_pkg::NWRT_WAIT_EOF;
        end
        else if (at_slot)
        begin
          if (slot_ok)
          begin
            go_nxt = 1'b1;
            state_nxt = nwrt_pkg::NWRT_IDLE;
          end
          else
            slot_nxt = slot_r + STEP;
        end
      end
      nwrt_pkg::NWRT_WAIT_EOF:
      begin
        cnt_nxt = '0;
        if (ev.eof_rise)
          state_nxt = nwrt_pkg::NWRT_DELAY;
      end
      nwrt_pkg::NWRT_DELAY:
      begin
        if (cnt_r == NOM)
        begin
          go_nxt = 1'b1;
          state_nxt = nwrt_pkg::NWRT_IDLE;
        end
      end
      default:
      begin
        cnt_nxt = '0;
        state_nxt = nwrt_pkg::NWRT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= nwrt_pkg::NWRT_IDLE;
      cnt_r <= '0;
      slot_r <= '0;
      reply_go_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      slot_r <= slot_nxt;
      reply_go_o <= go_nxt;
    end
  end

  // command attributes latched on acceptance
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      need_r <= '0;
      opt_r <= 1'b0;
      long_r <= 1'b0;
    end
    else if (accept)
    begin
      need_r <= need_sel;
      opt_r <= option_flag_i;
      long_r <= cmd_long_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag byte: a command refused while busy is reported in the next reply

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      refused_r <= 1'b0;
    else if (refuse)
      refused_r <= 1'b1;
    else if (go_nxt)
      refused_r <= 1'b0;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      reply_flags_o <= '0;
    else if (go_nxt)
      reply_flags_o <= {{(nwrt_pkg::BYTE_BITS - 1){1'b0}}, refused_r | refuse};
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  slot_grid_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (reply_go_o && !opt_r) |->
      (cnt_r >= NOM) && (((cnt_r - NOM) % STEP) == '0))
    else $error("reply outside slot grid");

  short_exec_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (reply_go_o && !opt_r && !long_r) |->
      (cnt_r >= W'(SHORT_CYC_4)) && (cnt_r >= need_r))
    else $error("short write replied too early");

  long_exec_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (reply_go_o && !opt_r && long_r) |-> (cnt_r >= W'(LONG_CYC_4)))
    else $error("long operation replied too early");

  opt_eof_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (reply_go_o && opt_r) |->
      ($past(state_r) == nwrt_pkg::NWRT_DELAY) && (cnt_r == NOM))
    else $error("option reply not after eof delay");

  wait_hold_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (state_r == nwrt_pkg::NWRT_WAIT_EOF && !ev.eof_rise) |=>
      (state_r == nwrt_pkg::NWRT_WAIT_EOF) && !reply_go_o)
    else $error("left eof wait without eof");

  carrier_count_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (state_r == nwrt_pkg::NWRT_EXEC && !ev.carrier_tick) |=> $stable(cnt_r))
    else $error("count moved without carrier edge");

  flag_byte_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (go_nxt && (refused_r || refuse)) |=>
      reply_flags_o[1] && (reply_flags_o[8:2] == 7'h00))
    else $error("flag byte layout wrong");

  flag_clear_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (go_nxt && !refused_r && !refuse) |=> (reply_flags_o == 8'h00))
    else $error("flag byte not clear");
endmodule // nwrt_reply_timer
`default_nettype wire

// ---- common/nwrt_pkg.sv ----
// constants for the write reply timing block
`default_nettype none
package nwrt_pkg;
  // carrier frequency in hertz
  localparam longint CARRIER_HZ = 64'd13560000;
  // execution times in microseconds
  localparam longint SINGLE_BLOCK_WRITE_TIME_US_4 = 64'd4660;
  localparam longint SINGLE_BLOCK_WRITE_TIME_US_256 = 64'd4700;
  localparam longint KEY_CHANGE_TIME_US_4 = 64'd4660;
  localparam longint KEY_CHANGE_TIME_US_256 = 64'd4700;
  localparam longint LONG_OP_TIME_US_4 = 64'd6670;
  localparam longint LONG_OP_TIME_US_256 = 64'd6700;
  // least times round up to whole carrier cycles
  localparam int unsigned SHORT_CYC_4 =
    int'((SINGLE_BLOCK_WRITE_TIME_US_4 * CARRIER_HZ + 64'd999999) / 64'd1000000);
  localparam int unsigned SHORT_CYC_256 =
    int'((SINGLE_BLOCK_WRITE_TIME_US_256 * CARRIER_HZ + 64'd999999) / 64'd1000000);
  localparam int unsigned LONG_CYC_4 =
    int'((LONG_OP_TIME_US_4 * CARRIER_HZ + 64'd999999) / 64'd1000000);
  localparam int unsigned LONG_CYC_256 =
    int'((LONG_OP_TIME_US_256 * CARRIER_HZ + 64'd999999) / 64'd1000000);
  // reply slot grid in carrier cycles
  localparam int unsigned NOMINAL_REPLY_DELAY = 4352;
  localparam int unsigned SLOT_STEP = 4096;
  localparam int CNT_W = 17;
  localparam int BYTE_BITS = 8;
  // flag byte bit one marks a refused command
  localparam int FLAG_REFUSED_POS = 1;
  typedef enum logic [2:0] {
    NWRT_IDLE = 3'h0,
    NWRT_ARMED = 3'h1,
    NWRT_EXEC = 3'h3,
    NWRT_WAIT_EOF = 3'h2,
    NWRT_DELAY = 3'h6
  } nwrt_state_t;
endpackage
`default_nettype wire

// ---- common/nwrt_sync_if.sv ----
// carrier and frame events passed from the sampler to the timer
`timescale 1ns/1ps
`default_nettype none
interface nwrt_sync_if;
  logic carrier_tick;
  logic eof_rise;
  modport src (output carrier_tick, output eof_rise);
  modport dst (input carrier_tick, input eof_rise);
endinterface
`default_nettype wire

// ---- logic/nwrt_link_sync.sv ----
// samples carrier and reader end of frame, emits one-cycle edge pulses
`timescale 1ns/1ps
`default_nettype none
module nwrt_link_sync (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic carrier_i,
  input wire logic eof_i,
  nwrt_sync_if.src ev
);
  logic [1:0] car_sync_r;
  logic [1:0] eof_sync_r;
  logic car_last_r;
  logic eof_last_r;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      car_sync_r <= 2'h0;
      eof_sync_r <= 2'h0;
      car_last_r <= 1'b0;
      eof_last_r <= 1'b0;
    end
    else
    begin
      car_sync_r <= {car_sync_r[0], carrier_i};
      eof_sync_r <= {eof_sync_r[0], eof_i};
      car_last_r <= car_sync_r[1];
      eof_last_r <= eof_sync_r[1];
    end
  end

  assign ev.carrier_tick = car_sync_r[1] & ~car_last_r;
  assign ev.eof_rise = eof_sync_r[1] & ~eof_last_r;
endmodule // nwrt_link_sync
`default_nettype wire

// ---- verification/nwrt_reader_model.sv ----
// reader side model: free running carrier and end-of-frame pulses
`timescale 1ns/1ps
`default_nettype none
module nwrt_reader_model (
  output var logic carrier_o,
  output var logic eof_o
);
  realtime eof_t;
  initial
  begin
    carrier_o = 1'b0;
    forever #32 carrier_o = ~carrier_o;
  end
  initial
  begin
    eof_o = 1'b0;
    eof_t = 0;
  end
  task automatic send_eof();
    @(posedge carrier_o);
    eof_o = 1'b1;
    eof_t = $realtime;
    repeat (2) @(posedge carrier_o);
    eof_o = 1'b0;
  endtask
endmodule // nwrt_reader_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the write reply timer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_i, sys_rst_i, cmd_start_i, cmd_long_i, coding_256_i, option_flag_i;
  wire carrier, eof;
  logic busy_o, reply_go_o;
  logic [8:1] reply_flags_o;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  nwrt_reader_model rdr (.carrier_o(carrier), .eof_o(eof));
  // short timings keep the run brief; expectations derive from these
  localparam int T_SHORT4 = 200;
  localparam int T_SHORT256 = 210;
  localparam int T_LONG4 = 300;
  localparam int T_LONG256 = 310;
  localparam int T_NOM = 40;
  localparam int T_STEP = 32;
  nwrt_reply_timer #(.SHORT_CYC_4(T_SHORT4), .SHORT_CYC_256(T_SHORT256), .LONG_CYC_4(T_LONG4),
    .LONG_CYC_256(T_LONG256), .NOMINAL_REPLY_DELAY(T_NOM), .SLOT_STEP(T_STEP)) DUT (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .carrier_i(carrier), .eof_i(eof),
    .cmd_start_i(cmd_start_i), .cmd_long_i(cmd_long_i), .coding_256_i(coding_256_i),
    .option_flag_i(option_flag_i), .busy_o(busy_o), .reply_go_o(reply_go_o),
    .reply_flags_o(reply_flags_o));
  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk8(input logic [8:1] got, input logic [8:1] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // delay from reader eof rise, in carrier cycles of 64 ns
  task automatic chk_win(input realtime d, input int cnt);
    total_checks++;
    if (d < (cnt - 1) * 64.0 || d > (cnt + 2) * 64.0)
    begin
      fail_count++;
      $display("MISMATCH %0t delay %0t expected %0d carriers", $time, d, cnt);
    end
  endtask
  // first reply slot at or after the execution time
  function automatic int slot_for(input int need);
    int s;
    s = T_NOM;
    while (s < need)
      s = s + T_STEP;
    return s;
  endfunction
  task automatic start(input logic lng, input logic c256, input logic opt);
    @(posedge clock_i);
    cmd_start_i <= 1'b1;
    cmd_long_i <= lng;
    coding_256_i <= c256;
    option_flag_i <= opt;
    @(posedge clock_i);
    cmd_start_i <= 1'b0;
    #1;
  endtask
  task automatic wait_reply(input int lim, output bit seen, output realtime t);
    seen = 0;
    t = 0;
    for (int i = 0; i < lim && !seen; i++)
    begin
      @(posedge clock_i);
      #1;
      if (reply_go_o === 1'b1)
      begin
        seen = 1;
        t = $realtime;
      end
    end
  endtask
  // option clear: reply in the first slot after execution, optional refused start
  task automatic slot_op(input logic lng, input logic c256, input int need, input bit refuse);
    bit seen;
    realtime t;
    start(lng, c256, 1'b0);
    chk8({7'h00, busy_o}, 8'h01);
    if (refuse)
      start(1'b1, 1'b1, 1'b1);
    rdr.send_eof();
    wait_reply(8000, seen, t);
    chk8({7'h00, seen}, 8'h01);
    chk_win(t - rdr.eof_t, slot_for(need));
    chk8(reply_flags_o, {7'h00, refuse});
    chk8({7'h00, busy_o}, 8'h00);
  endtask
  // option set: eof during execution ignored, reply follows the later eof
  task automatic opt_op(input logic lng, input logic c256, input int need);
    bit seen;
    realtime t;
    start(lng, c256, 1'b1);
    rdr.send_eof();
    repeat (200) @(posedge clock_i);
    rdr.send_eof();
    // about 12.8 system clocks per carrier cycle
    wait_reply(need * 13, seen, t);
    chk8({7'h00, seen}, 8'h00);
    rdr.send_eof();
    wait_reply(T_NOM * 13 + 200, seen, t);
    chk8({7'h00, seen}, 8'h01);
    chk_win(t - rdr.eof_t, T_NOM);
    chk8(reply_flags_o, 8'h00);
  endtask
  initial
  begin
    sys_rst_i = 1'b1;
    cmd_start_i = 1'b0;
    cmd_long_i = 1'b0;
    coding_256_i = 1'b0;
    option_flag_i = 1'b0;
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    chk8({6'h00, busy_o, reply_go_o}, 8'h00);
    chk8(reply_flags_o, 8'h00);
    slot_op(1'b0, 1'b0, T_SHORT4, 0);
    slot_op(1'b0, 1'b1, T_SHORT256, 0);
    slot_op(1'b1, 1'b0, T_LONG4, 0);
    slot_op(1'b1, 1'b1, T_LONG256, 1);
    slot_op(1'b0, 1'b0, T_SHORT4, 0);
    opt_op(1'b0, 1'b0, T_SHORT4);
    opt_op(1'b1, 1'b1, T_LONG256);
    conclude();
  end
endmodule // tb
`default_nettype wire
